// ---- hdl/axil_reg_port.sv ----
// axi4-lite slave that turns bus transfers into register strobes
`timescale 1ns/1ps
module axil_reg_port (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [line_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [line_regs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// register side
	output logic wr_en,
	output logic [line_regs_pkg::IDX_W-1:0] wr_idx,
	output logic [7:0] wr_data,
	input wire logic wr_hit,
	output logic rd_en,
	output logic [line_regs_pkg::IDX_W-1:0] rd_idx,
	input wire logic [7:0] rd_data,
	input wire logic rd_hit
);
	import line_regs_pkg::*;

	logic aw_full_ff, w_full_ff, strb0_ff;
	logic [IDX_W-1:0] aw_idx_ff;
	logic [7:0] wdata_ff;
	logic wr_fire;

	assign s_axi_awready = ~aw_full_ff;
	assign s_axi_wready = ~w_full_ff;
	assign s_axi_arready = ~s_axi_rvalid;
	// address and data are held until both have arrived and the response slot is free
	assign wr_fire = aw_full_ff & w_full_ff & ~s_axi_bvalid;
	// only byte lane 0 carries register bits; a write without it stores nothing
	assign wr_en = wr_fire & strb0_ff;
	assign wr_idx = aw_idx_ff;
	assign wr_data = wdata_ff;
	assign rd_en = s_axi_arvalid & s_axi_arready;
	assign rd_idx = s_axi_araddr[ADDR_W-1:2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_ff <= 1'b0;
			aw_idx_ff <= '0;
		end else if (s_axi_awvalid & s_axi_awready) begin
			aw_full_ff <= 1'b1;
			aw_idx_ff <= s_axi_awaddr[ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_full_ff <= 1'b0;
			wdata_ff <= RST_REG;
			strb0_ff <= 1'b0;
		end else if (s_axi_wvalid & s_axi_wready) begin
			w_full_ff <= 1'b1;
			wdata_ff <= s_axi_wdata[7:0];
			strb0_ff <= s_axi_wstrb[0];
		end else if (wr_fire) begin
			w_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_en) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h0, rd_data};
			s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // axil_reg_port

// ---- hdl/line_channel_global_regs.sv ----
// global register bank of the twelve channel line unit with the channel 11 block
`timescale 1ns/1ps
module line_channel_global_regs #(
	parameter logic [7:0] PART_ID = 8'h5a,
	parameter logic [7:0] REV_ID = 8'h01
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite slave
	input wire logic [line_regs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [line_regs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// interrupt
	output logic irq,
	// master transmit enable pin
	input wire logic master_tx_enable,
	// channel event sources
	input wire logic [line_regs_pkg::CH_NUM-2:0] chan_irq_req,
	input wire logic [7:0] ch11_source_event,
	input wire logic [7:0] ch11_alarm_in,
	input wire logic ch11_error_pulse,
	// channel 11 control outputs
	output logic [7:0] ch11_transmit_ctrl,
	output logic [7:0] ch11_receive_ctrl,
	output logic [7:0] ch11_channel_ctrl,
	output logic [7:0] ch11_jitter_atten_ctrl,
	// transmit line
	input wire logic [line_regs_pkg::CH_NUM-1:0] tx_pulse_pos,
	input wire logic [line_regs_pkg::CH_NUM-1:0] tx_pulse_neg,
	output logic [line_regs_pkg::CH_NUM-1:0] tx_line_positive,
	output logic [line_regs_pkg::CH_NUM-1:0] tx_line_negative,
	output logic [line_regs_pkg::CH_NUM-1:0] line_driver_on,
	// receive line
	input wire logic [line_regs_pkg::CH_NUM-1:0] rx_line_positive,
	input wire logic [line_regs_pkg::CH_NUM-1:0] rx_line_negative,
	output logic [line_regs_pkg::CH_NUM-1:0] line_receiver_on,
	output logic [line_regs_pkg::CH_NUM-1:0] rx_pulse_pos,
	output logic [line_regs_pkg::CH_NUM-1:0] rx_pulse_neg
);
	import line_regs_pkg::*;

	logic wr_en, wr_hit, rd_en, rd_hit;
	logic [IDX_W-1:0] wr_idx, rd_idx;
	logic [7:0] wr_data, rd_data;

	logic [GROUP_W-1:0] tx_lo_ff, tx_hi_ff, rx_lo_ff, rx_hi_ff, gie_lo_ff, gie_hi_ff;
	logic [7:0] src_en_ff, src_st_ff, alarm_ff;
	logic [7:0] err_hold_ff;
	logic [15:0] err_count_ff;
	logic [IRQ_W-1:0] irq_st_ff, irq_mask_ff;
	logic grp_pend_ff, master_ff;

	logic [GROUP_W-1:0] nxt_tx_lo, nxt_tx_hi;
	logic [7:0] nxt_src_st;
	logic [15:0] nxt_err_count;
	logic [IRQ_W-1:0] nxt_irq_st, nxt_irq_mask, irq_event;
	logic [CH_NUM-1:0] chan_flag, tx_enable, rx_enable;
	logic grp_pend, src_read, src_new;

	axil_reg_port u_port (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awprot(s_axi_awprot),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arprot(s_axi_arprot),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_hit(wr_hit),
		.rd_en(rd_en),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_hit(rd_hit)
	);

	// write strobes, one per writable register
	logic w_tx_lo, w_tx_hi, w_rx_lo, w_rx_hi, w_gie_lo, w_gie_hi, w_src_en;
	logic w_tc, w_rc, w_cc, w_ja, w_err_hi, w_err_lo, w_err_hold, w_irq_st, w_irq_mask;
	assign w_tx_lo = wr_en & (wr_idx == IDX_TX_LO);
	assign w_tx_hi = wr_en & (wr_idx == IDX_TX_HI);
	assign w_rx_lo = wr_en & (wr_idx == IDX_RX_LO);
	assign w_rx_hi = wr_en & (wr_idx == IDX_RX_HI);
	assign w_gie_lo = wr_en & (wr_idx == IDX_GIE_LO);
	assign w_gie_hi = wr_en & (wr_idx == IDX_GIE_HI);
	assign w_src_en = wr_en & (wr_idx == IDX_SRC_EN);
	assign w_tc = wr_en & (wr_idx == IDX_TC);
	assign w_rc = wr_en & (wr_idx == IDX_RC);
	assign w_cc = wr_en & (wr_idx == IDX_CC);
	assign w_ja = wr_en & (wr_idx == IDX_JA);
	assign w_err_hi = wr_en & (wr_idx == IDX_ERR_HI);
	assign w_err_lo = wr_en & (wr_idx == IDX_ERR_LO);
	assign w_err_hold = wr_en & (wr_idx == IDX_ERR_HOLD);
	assign w_irq_st = wr_en & (wr_idx == IDX_IRQ_ST);
	assign w_irq_mask = wr_en & (wr_idx == IDX_IRQ_MASK);

	// read-only registers are mapped, so a write to them is accepted but changes nothing
	assign wr_hit = w_tx_lo | w_tx_hi | w_rx_lo | w_rx_hi | w_gie_lo | w_gie_hi | w_src_en |
		w_tc | w_rc | w_cc | w_ja | w_err_hi | w_err_lo | w_err_hold | w_irq_st | w_irq_mask |
		(wr_idx == IDX_GIS_LO) | (wr_idx == IDX_GIS_HI) | (wr_idx == IDX_PART) |
		(wr_idx == IDX_REV) | (wr_idx == IDX_SRC_ST) | (wr_idx == IDX_ALARM);

	// only the six channel bits are stored; bits 7 and 6 are dropped
	assign nxt_tx_lo = w_tx_lo ? wr_data[GROUP_W-1:0] : tx_lo_ff;
	assign nxt_tx_hi = w_tx_hi ? wr_data[GROUP_W-1:0] : tx_hi_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_lo_ff <= RST_GROUP;
			tx_hi_ff <= RST_GROUP;
		end else begin
			tx_lo_ff <= nxt_tx_lo;
			tx_hi_ff <= nxt_tx_hi;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_lo_ff <= RST_GROUP;
			rx_hi_ff <= RST_GROUP;
			gie_lo_ff <= RST_GROUP;
			gie_hi_ff <= RST_GROUP;
		end else begin
			if (w_rx_lo) rx_lo_ff <= wr_data[GROUP_W-1:0];
			if (w_rx_hi) rx_hi_ff <= wr_data[GROUP_W-1:0];
			if (w_gie_lo) gie_lo_ff <= wr_data[GROUP_W-1:0];
			if (w_gie_hi) gie_hi_ff <= wr_data[GROUP_W-1:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_en_ff <= RST_REG;
			ch11_transmit_ctrl <= RST_REG;
			ch11_receive_ctrl <= RST_REG;
			ch11_channel_ctrl <= RST_REG;
			ch11_jitter_atten_ctrl <= RST_REG;
			err_hold_ff <= RST_REG;
			irq_mask_ff <= RST_IRQ;
		end else begin
			if (w_src_en) src_en_ff <= wr_data;
			if (w_tc) ch11_transmit_ctrl <= wr_data;
			if (w_rc) ch11_receive_ctrl <= wr_data;
			if (w_cc) ch11_channel_ctrl <= wr_data;
			if (w_ja) ch11_jitter_atten_ctrl <= wr_data;
			if (w_err_hold) err_hold_ff <= wr_data;
			if (w_irq_mask) irq_mask_ff <= wr_data[IRQ_W-1:0];
		end
	end

	// source status: a new event in the read cycle survives the clear
	assign src_read = rd_en & (rd_idx == IDX_SRC_ST);
	assign nxt_src_st = (src_read ? 8'h00 : src_st_ff) | ch11_source_event;
	assign src_new = |(ch11_source_event & ~src_st_ff);

	// the error counter saturates rather than wrapping, so a long burst reads as full scale
	always_comb begin
		nxt_err_count = err_count_ff;
		if (w_err_hi) begin
			nxt_err_count = {wr_data, err_count_ff[7:0]};
		end else if (w_err_lo) begin
			nxt_err_count = {err_count_ff[15:8], wr_data};
		end else if (ch11_error_pulse && err_count_ff != 16'hffff) begin
			nxt_err_count = err_count_ff + 16'h0001;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			src_st_ff <= RST_REG;
			alarm_ff <= RST_REG;
			err_count_ff <= RST_COUNT;
		end else begin
			src_st_ff <= nxt_src_st;
			alarm_ff <= ch11_alarm_in;
			err_count_ff <= nxt_err_count;
		end
	end

	// group flags: channels 0-10 report from outside, channel 11 from its own sources
	assign chan_flag = {|(src_st_ff & src_en_ff), chan_irq_req};
	assign grp_pend = |(chan_flag & {gie_hi_ff, gie_lo_ff});

	// block interrupt: sticky, write one to clear, a same-cycle event wins
	assign irq_event[IRQ_SRC] = src_new;
	assign irq_event[IRQ_GRP] = grp_pend & ~grp_pend_ff;
	assign irq_event[IRQ_MASTER] = master_tx_enable ^ master_ff;
	assign nxt_irq_st = (w_irq_st ? irq_st_ff & ~wr_data[IRQ_W-1:0] : irq_st_ff) | irq_event;
	// the output follows the mask in the same cycle as the mask register itself
	assign nxt_irq_mask = w_irq_mask ? wr_data[IRQ_W-1:0] : irq_mask_ff;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_st_ff <= RST_IRQ;
			grp_pend_ff <= 1'b0;
			master_ff <= master_tx_enable; // no false change event right after reset
			irq <= 1'b0;
		end else begin
			irq_st_ff <= nxt_irq_st;
			grp_pend_ff <= grp_pend;
			master_ff <= master_tx_enable;
			irq <= |(nxt_irq_st & nxt_irq_mask);
		end
	end

	// read mux
	always_comb begin
		rd_data = 8'h00;
		rd_hit = 1'b1;
		unique case (rd_idx)
			IDX_TX_LO: rd_data = {2'h0, tx_lo_ff};
			IDX_TX_HI: rd_data = {2'h0, tx_hi_ff};
			IDX_RX_LO: rd_data = {2'h0, rx_lo_ff};
			IDX_RX_HI: rd_data = {2'h0, rx_hi_ff};
			IDX_GIE_LO: rd_data = {2'h0, gie_lo_ff};
			IDX_GIS_LO: rd_data = {2'h0, chan_flag[GROUP_W-1:0]};
			IDX_GIE_HI: rd_data = {2'h0, gie_hi_ff};
			IDX_GIS_HI: rd_data = {2'h0, chan_flag[CH_NUM-1:GROUP_W]};
			IDX_PART: rd_data = PART_ID;
			IDX_REV: rd_data = REV_ID;
			IDX_SRC_EN: rd_data = src_en_ff;
			IDX_SRC_ST: rd_data = src_st_ff;
			IDX_ALARM: rd_data = alarm_ff;
			IDX_TC: rd_data = ch11_transmit_ctrl;
			IDX_RC: rd_data = ch11_receive_ctrl;
			IDX_CC: rd_data = ch11_channel_ctrl;
			IDX_JA: rd_data = ch11_jitter_atten_ctrl;
			IDX_ERR_HI: rd_data = err_count_ff[15:8];
			IDX_ERR_LO: rd_data = err_count_ff[7:0];
			IDX_ERR_HOLD: rd_data = err_hold_ff;
			IDX_IRQ_ST: rd_data = {5'h00, irq_st_ff};
			IDX_IRQ_MASK: rd_data = {5'h00, irq_mask_ff};
			default: rd_hit = 1'b0;
		endcase
	end

	assign tx_enable = {tx_hi_ff, tx_lo_ff};
	assign rx_enable = {rx_hi_ff, rx_lo_ff};

	line_channel_io #(
		.CH_NUM(CH_NUM)
	) u_io (
		.aclk(aclk),
		.aresetn(aresetn),
		.tx_enable(tx_enable),
		.rx_enable(rx_enable),
		.master_tx_enable(master_tx_enable),
		.tx_pulse_pos(tx_pulse_pos),
		.tx_pulse_neg(tx_pulse_neg),
		.tx_line_positive(tx_line_positive),
		.tx_line_negative(tx_line_negative),
		.line_driver_on(line_driver_on),
		.rx_line_positive(rx_line_positive),
		.rx_line_negative(rx_line_negative),
		.line_receiver_on(line_receiver_on),
		.rx_pulse_pos(rx_pulse_pos),
		.rx_pulse_neg(rx_pulse_neg)
	);

	// checks
	sequence s_write_tx_lo;
		w_tx_lo && master_tx_enable;
	endsequence

	property p_tx_lo_drive;
		@(posedge aclk) disable iff (!aresetn)
		s_write_tx_lo ##1 master_tx_enable |=> line_driver_on[GROUP_W-1:0] == $past(tx_lo_ff);
	endproperty
	a_tx_lo_drive: assert property (p_tx_lo_drive) else $error("low driver enables wrong");

	property p_tx_hi_drive;
		@(posedge aclk) disable iff (!aresetn)
		w_tx_hi ##1 master_tx_enable |=> line_driver_on[CH_NUM-1:GROUP_W] == $past(tx_hi_ff);
	endproperty
	a_tx_hi_drive: assert property (p_tx_hi_drive) else $error("high driver enables wrong");

	property p_off_floats;
		@(posedge aclk) disable iff (!aresetn)
		!tx_enable[0] |=> !line_driver_on[0] && !tx_line_positive[0] && !tx_line_negative[0];
	endproperty
	a_off_floats: assert property (p_off_floats) else $error("driver on while disabled");

	property p_on_sends;
		@(posedge aclk) disable iff (!aresetn)
		tx_enable[0] && master_tx_enable && tx_pulse_pos[0] |=> tx_line_positive[0];
	endproperty
	a_on_sends: assert property (p_on_sends) else $error("enabled driver lost a pulse");

	property p_master_gate;
		@(posedge aclk) disable iff (!aresetn)
		!master_tx_enable |=> line_driver_on == '0;
	endproperty
	a_master_gate: assert property (p_master_gate) else $error("driver on without master");

	property p_rx_follow;
		@(posedge aclk) disable iff (!aresetn)
		w_rx_hi |-> ##2 line_receiver_on[CH_NUM-1:GROUP_W] == $past(wr_data[GROUP_W-1:0], 2);
	endproperty
	a_rx_follow: assert property (p_rx_follow) else $error("receiver enable not applied");

	property p_read_clears;
		@(posedge aclk) disable iff (!aresetn)
		src_read && ch11_source_event == 8'h00 |=> src_st_ff == 8'h00;
	endproperty
	a_read_clears: assert property (p_read_clears) else $error("source status not cleared");

	property p_event_kept;
		@(posedge aclk) disable iff (!aresetn)
		ch11_source_event[0] |=> src_st_ff[0];
	endproperty
	a_event_kept: assert property (p_event_kept) else $error("source event lost");

	property p_reserved_zero;
		@(posedge aclk) disable iff (!aresetn)
		rd_en && (rd_idx == IDX_TX_LO || rd_idx == IDX_TX_HI || rd_idx == IDX_RX_LO ||
			rd_idx == IDX_RX_HI) |=> s_axi_rdata[7:6] == 2'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_alarm_ro;
		@(posedge aclk) disable iff (!aresetn)
		wr_en && wr_idx == IDX_ALARM |=> alarm_ff == $past(ch11_alarm_in);
	endproperty
	a_alarm_ro: assert property (p_alarm_ro) else $error("alarm altered by write");
endmodule // line_channel_global_regs

// ---- hdl/line_channel_io.sv ----
// per-channel line driver and receiver gating
`timescale 1ns/1ps
module line_channel_io #(
	parameter int CH_NUM = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// enables
	input wire logic [CH_NUM-1:0] tx_enable,
	input wire logic [CH_NUM-1:0] rx_enable,
	input wire logic master_tx_enable,
	// transmit pulses and line pins
	input wire logic [CH_NUM-1:0] tx_pulse_pos,
	input wire logic [CH_NUM-1:0] tx_pulse_neg,
	output logic [CH_NUM-1:0] tx_line_positive,
	output logic [CH_NUM-1:0] tx_line_negative,
	output logic [CH_NUM-1:0] line_driver_on,
	// receive pins and recovered pulses
	input wire logic [CH_NUM-1:0] rx_line_positive,
	input wire logic [CH_NUM-1:0] rx_line_negative,
	output logic [CH_NUM-1:0] line_receiver_on,
	output logic [CH_NUM-1:0] rx_pulse_pos,
	output logic [CH_NUM-1:0] rx_pulse_neg
);
	for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
		logic drv_on;
		// the master pin overrides every transmit register enable; receiver enables are not gated by it
		assign drv_on = tx_enable[i] & master_tx_enable;
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				line_driver_on[i] <= 1'b0;
				tx_line_positive[i] <= 1'b0;
				tx_line_negative[i] <= 1'b0;
				line_receiver_on[i] <= 1'b0;
				rx_pulse_pos[i] <= 1'b0;
				rx_pulse_neg[i] <= 1'b0;
			end else begin
				line_driver_on[i] <= drv_on;
				tx_line_positive[i] <= drv_on & tx_pulse_pos[i];
				tx_line_negative[i] <= drv_on & tx_pulse_neg[i];
				line_receiver_on[i] <= rx_enable[i];
				// a receiver that is off reports no pulses
				rx_pulse_pos[i] <= rx_enable[i] & rx_line_positive[i];
				rx_pulse_neg[i] <= rx_enable[i] & rx_line_negative[i];
			end
		end
	end
endmodule // line_channel_io

// ---- hdl/line_regs_pkg.sv ----
// register map, field layout and reset values of the line channel register bank
package line_regs_pkg;
	localparam int CH_NUM = 12;
	localparam int GROUP_W = 6;
	localparam int IDX_W = 10;
	localparam int ADDR_W = 12;
	localparam int IRQ_W = 3;

	// register indices; byte address is four times the index
	localparam logic [9:0] IDX_TX_LO = 10'h000;
	localparam logic [9:0] IDX_RX_LO = 10'h008;
	localparam logic [9:0] IDX_GIE_LO = 10'h060;
	localparam logic [9:0] IDX_GIS_LO = 10'h061;
	localparam logic [9:0] IDX_PART = 10'h06e;
	localparam logic [9:0] IDX_REV = 10'h06f;
	localparam logic [9:0] IDX_TX_HI = 10'h080;
	localparam logic [9:0] IDX_RX_HI = 10'h088;
	localparam logic [9:0] IDX_SRC_EN = 10'h0d1;
	localparam logic [9:0] IDX_SRC_ST = 10'h0d2;
	localparam logic [9:0] IDX_ALARM = 10'h0d3;
	localparam logic [9:0] IDX_TC = 10'h0d4;
	localparam logic [9:0] IDX_RC = 10'h0d5;
	localparam logic [9:0] IDX_CC = 10'h0d6;
	localparam logic [9:0] IDX_JA = 10'h0d7;
	localparam logic [9:0] IDX_ERR_HI = 10'h0da;
	localparam logic [9:0] IDX_ERR_LO = 10'h0db;
	localparam logic [9:0] IDX_ERR_HOLD = 10'h0dc;
	localparam logic [9:0] IDX_GIE_HI = 10'h0e0;
	localparam logic [9:0] IDX_GIS_HI = 10'h0e1;
	localparam logic [9:0] IDX_IRQ_ST = 10'h100;
	localparam logic [9:0] IDX_IRQ_MASK = 10'h101;

	// interrupt status bit positions
	localparam int IRQ_SRC = 0;
	localparam int IRQ_GRP = 1;
	localparam int IRQ_MASTER = 2;

	// values after reset
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [5:0] RST_GROUP = 6'h00;
	localparam logic [2:0] RST_IRQ = 3'h0;
	localparam logic [15:0] RST_COUNT = 16'h0000;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- tb/line_channel_global_regs_tb_top.sv ----
// self-checking bench for the line channel register bank
`timescale 1ns/1ps
module line_channel_global_regs_tb_top;
	import line_regs_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic master_tx_enable, ch11_error_pulse;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [CH_NUM-2:0] chan_irq_req;
	logic [7:0] ch11_source_event, ch11_alarm_in, ch11_transmit_ctrl, ch11_receive_ctrl, rv;
	logic [7:0] ch11_channel_ctrl, ch11_jitter_atten_ctrl;
	logic [CH_NUM-1:0] tx_pulse_pos, tx_pulse_neg, tx_line_positive, tx_line_negative;
	logic [CH_NUM-1:0] line_driver_on, rx_line_positive, rx_line_negative, line_receiver_on;
	logic [CH_NUM-1:0] rx_pulse_pos, rx_pulse_neg;
	logic [9:0] grp_idx [6] = '{IDX_TX_LO, IDX_RX_LO, IDX_TX_HI, IDX_RX_HI, IDX_GIE_LO, IDX_GIE_HI};
	logic [9:0] ctl_idx [7] = '{IDX_SRC_EN, IDX_TC, IDX_RC, IDX_CC, IDX_JA, IDX_ERR_HI, IDX_ERR_HOLD};
	int errors, check_count, cycles;
	// identity values are arbitrary
	line_channel_global_regs #(.PART_ID(8'h3c), .REV_ID(8'h07)) line_channel_global_regs_inst (.*);
	initial begin
		aclk = 0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic print_verdict();
		if (errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			errors = errors + 1;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// handshakes are judged at the falling edge, where the inputs of the next edge are settled
	task automatic wr(input logic [9:0] i, input logic [7:0] d, output logic [1:0] r);
		logic ta, tw, pa, pw, b;
		@(posedge aclk);
		s_axi_awaddr <= {i, 2'h0};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		pa = 1;
		pw = 1;
		while (pa || pw) begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
			pa = pa && !ta;
			pw = pw && !tw;
		end
		do begin
			@(negedge aclk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
		end while (b !== 1'b1);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [9:0] i, output logic [7:0] d, output logic [1:0] r);
		logic t;
		@(posedge aclk);
		s_axi_araddr <= {i, 2'h0};
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge aclk);
			t = s_axi_arready;
			@(posedge aclk);
		end while (t !== 1'b1);
		s_axi_arvalid <= 0;
		do begin
			@(negedge aclk);
			t = s_axi_rvalid;
			d = s_axi_rdata[7:0];
			r = s_axi_rresp;
			@(posedge aclk);
		end while (t !== 1'b1);
		s_axi_rready <= 0;
	endtask
	task automatic pulse_src();
		@(posedge aclk) ch11_source_event <= 8'h81;
		@(posedge aclk) ch11_source_event <= 8'h00;
		repeat (2) @(negedge aclk);
	endtask
	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		s_axi_wstrb = 4'hf;
		{errors, check_count, cycles} = '0;
		{ch11_error_pulse, ch11_source_event} = '0;
		master_tx_enable = 1;
		chan_irq_req = 11'h041;
		ch11_alarm_in = 8'h5c;
		tx_pulse_pos = 12'hfff;
		tx_pulse_neg = 12'hfff;
		rx_line_positive = 12'h5a5;
		rx_line_negative = 12'hfff;
		aresetn = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1;
		rd(IDX_TX_LO, rv, rs);
		chk(rv, RST_REG);
		for (int k = 0; k < 6; k++) begin
			wr(grp_idx[k], 8'hff, rs);
			rd(grp_idx[k], rv, rs);
			chk({rs, rv}, {RESP_OKAY, 8'h3f});
		end
		repeat (2) @(negedge aclk);
		chk({line_driver_on, tx_line_positive}, 24'hfff_fff);
		chk({line_receiver_on, rx_pulse_pos}, 24'hfff_5a5);
		chk(rx_pulse_neg, 12'hfff);
		wr(IDX_RX_HI, 8'h00, rs);
		wr(IDX_TX_LO, 8'h2a, rs);
		repeat (2) @(negedge aclk);
		chk({line_driver_on, tx_line_negative}, 24'hfea_fea);
		chk({rx_pulse_pos, rx_pulse_neg}, 24'h025_03f);
		@(posedge aclk) master_tx_enable <= 0;
		repeat (3) @(negedge aclk);
		chk(line_driver_on, 12'h000);
		for (int k = 0; k < 7; k++) begin
			wr(ctl_idx[k], 8'hc0 + k[7:0], rs);
			rd(ctl_idx[k], rv, rs);
			chk(rv, 8'hc0 + k[7:0]);
		end
		chk({ch11_transmit_ctrl, ch11_receive_ctrl, ch11_channel_ctrl, ch11_jitter_atten_ctrl},
			32'hc1c2c3c4);
		wr(IDX_ERR_LO, 8'h05, rs);
		@(posedge aclk) ch11_error_pulse <= 1;
		@(posedge aclk) ch11_error_pulse <= 0;
		rd(IDX_ERR_LO, rv, rs);
		chk(rv, 8'h06);
		wr(IDX_SRC_EN, 8'h00, rs);
		for (int k = 0; k < 2; k++) begin
			rd(k ? IDX_GIS_HI : IDX_GIS_LO, rv, rs);
			chk(rv, 8'h01);
		end
		wr(IDX_ALARM, 8'h00, rs);
		rd(IDX_ALARM, rv, rs);
		chk(rv, 8'h5c);
		wr(IDX_PART, 8'h00, rs);
		wr(IDX_REV, 8'h00, rs);
		rd(IDX_PART, rv, rs);
		chk(rv, 8'h3c);
		rd(IDX_REV, rv, rs);
		chk(rv, 8'h07);
		wr(IDX_IRQ_ST, 8'h07, rs);
		pulse_src();
		chk(irq, 1'b0);
		wr(IDX_IRQ_MASK, 8'h01, rs);
		@(negedge aclk);
		chk(irq, 1'b1);
		rd(IDX_SRC_ST, rv, rs);
		chk(rv, 8'h81);
		rd(IDX_SRC_ST, rv, rs);
		chk(rv, 8'h00);
		wr(IDX_IRQ_ST, 8'h07, rs);
		@(negedge aclk);
		chk(irq, 1'b0);
		wr(10'h0d8, 8'h11, rs);
		chk(rs, RESP_SLVERR);
		rd(10'h0d8, rv, rs);
		chk({rs, rv}, {RESP_SLVERR, 8'h00});
		print_verdict();
	end
endmodule // line_channel_global_regs_tb_top
